/* verilog/dhbp_pkg.sv */
// Package of constants for the decoder host byte port
package dhbp_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned DRIVE_HIGH_NS   = 10;
   localparam int unsigned DRIVE_HIGH_CYC  =
      (DRIVE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HOLD_CYC_W      = 4;
   localparam logic [3:0]  HOLD_CYC        = 4'h2;
   localparam int unsigned WORD_BYTES      = 4;
   localparam int unsigned PIO_COUNT       = 32;
   // Pins 0, 11..18 inputs; 19..26 outputs; rest inputs
   localparam logic [31:0] PIO_DIR_RST     = 32'h07f8_0000;
   localparam logic [31:0] PIO_OUT_RST     = 32'h0000_0000;
   localparam logic [1:0]  SEL_QUEUE       = 2'h0;
   localparam logic [1:0]  SEL_REG         = 2'h1;
   localparam logic [1:0]  SEL_MEM         = 2'h2;
   localparam logic [1:0]  BYTE_IDX_RST    = 2'h0;
endpackage

/* verilog/dhbp_od_pin.sv */
`timescale 1ns/1ps
// Open-drain output with brief active-high drive before release
module dhbp_od_pin #(
   parameter int unsigned HIGH_CYC = 1
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // Request: 1 asserts the active-low pin
   input  wire logic assert_req,
   // Pin
   output logic      pin_o,
   output logic      pin_oe
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic       pin_q;
   logic       pin_d;
   logic       oe_q;
   logic       oe_d;

   always_comb begin
      cnt_d = cnt_q;
      pin_d = pin_q;
      oe_d  = oe_q;
      if (assert_req) begin
         pin_d = 1'b0;
         oe_d  = 1'b1;
         cnt_d = 4'(HIGH_CYC);
      end else if (oe_q && !pin_q) begin
         // Drive high first so the pull-up need not charge the line
         pin_d = 1'b1;
      end else if (oe_q && cnt_q > 4'h1) begin
         cnt_d = cnt_q - 4'h1;
      end else begin
         oe_d  = 1'b0;
         pin_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 4'h0;
         pin_q <= 1'b1;
         oe_q  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         pin_q <= pin_d;
         oe_q  <= oe_d;
      end
   end

   assign pin_o  = pin_q;
   assign pin_oe = oe_q;

   high_before_release_a: assert property (@(posedge clk) disable iff (!nrst)
      (oe_q && !pin_q && !assert_req) |=> (oe_q && pin_q))
      else $error("pin released without driving high");
   release_bound_a: assert property (@(posedge clk) disable iff (!nrst)
      (oe_q && pin_q && !assert_req && cnt_q <= 4'h1) |=> !oe_q)
      else $error("pin not released after high drive");
endmodule // dhbp_od_pin

/* verilog/dhbp_top.sv */
`timescale 1ns/1ps
// Host byte port of the decoder: queue, register and memory access
module dhbp_top #(
   parameter int unsigned PIO_W = dhbp_pkg::PIO_COUNT
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              nrst,
   // Host strobes, asynchronous
   input  wire logic              port_sel_n,
   input  wire logic              host_wr_n,
   input  wire logic [1:0]        target_sel,
   // Host data lane
   input  wire logic [7:0]        host_byte_lane_i,
   output logic      [7:0]        host_byte_lane_o,
   output logic                   host_byte_lane_oe,
   // Transfer hold, open drain
   output logic                   transfer_hold_ack_n_o,
   output logic                   transfer_hold_ack_n_oe,
   // Host interrupt, open drain
   output logic                   host_int_n_o,
   output logic                   host_int_n_oe,
   // Decoder core side
   output logic                   queue_valid,
   output logic      [31:0]       queue_word,
   input  wire logic              queue_ready,
   output logic                   acc_req,
   output logic                   acc_wr,
   output logic                   acc_mem,
   output logic      [7:0]        acc_wdata,
   input  wire logic              acc_done,
   input  wire logic [7:0]        acc_rdata,
   input  wire logic              core_irq,
   // Programmable I/O
   input  wire logic [PIO_W-1:0]  prog_io_pin_i,
   output logic      [PIO_W-1:0]  prog_io_pin_o,
   output logic      [PIO_W-1:0]  prog_io_pin_oe,
   input  wire logic              pio_set_we,
   input  wire logic [PIO_W-1:0]  pio_dir_set,
   input  wire logic [PIO_W-1:0]  pio_out_set,
   output logic      [PIO_W-1:0]  pio_in_val
);
   typedef enum logic [2:0] {
      DHBP_IDLE, DHBP_QUEUE, DHBP_ACCESS, DHBP_DONE
   } dhbp_state_t;

   // Synchronisers for host pins and programmable I/O inputs
   logic [1:0]  sel_s_q;
   logic [1:0]  wr_s_q;
   logic [1:0]  tgt1_s_q;
   logic [1:0]  tgt0_s_q;
   logic [7:0]  lane_s1_q;
   logic [7:0]  lane_s2_q;
   logic [PIO_W-1:0] pio_s1_q;
   logic [PIO_W-1:0] pio_s2_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sel_s_q   <= 2'h3;
         wr_s_q    <= 2'h3;
         tgt1_s_q  <= 2'h0;
         tgt0_s_q  <= 2'h0;
         lane_s1_q <= 8'h00;
         lane_s2_q <= 8'h00;
         pio_s1_q  <= '0;
         pio_s2_q  <= '0;
      end else begin
         sel_s_q   <= {sel_s_q[0], port_sel_n};
         wr_s_q    <= {wr_s_q[0], host_wr_n};
         tgt1_s_q  <= {tgt1_s_q[0], target_sel[1]};
         tgt0_s_q  <= {tgt0_s_q[0], target_sel[0]};
         lane_s1_q <= host_byte_lane_i;
         lane_s2_q <= lane_s1_q;
         pio_s1_q  <= prog_io_pin_i;
         pio_s2_q  <= pio_s1_q;
      end
   end

   logic       sel_n;
   logic       wr_n;
   logic [1:0] tgt;
   assign sel_n = sel_s_q[1];
   assign wr_n  = wr_s_q[1];
   assign tgt   = {tgt1_s_q[1], tgt0_s_q[1]};

   // Transfer state
   dhbp_state_t st_q;
   dhbp_state_t st_d;
   logic [1:0]  bidx_q;
   logic [1:0]  bidx_d;
   logic [31:0] word_q;
   logic [31:0] word_d;
   logic        qv_q;
   logic        qv_d;
   logic        req_q;
   logic        req_d;
   logic        wr_q;
   logic        wr_d;
   logic        mem_q;
   logic        mem_d;
   logic [7:0]  wdat_q;
   logic [7:0]  wdat_d;
   logic [7:0]  rdat_q;
   logic [7:0]  rdat_d;
   logic        rd_oe_q;
   logic        rd_oe_d;
   logic        hold_q;
   logic        hold_d;

   always_comb begin
      st_d    = st_q;
      bidx_d  = bidx_q;
      word_d  = word_q;
      qv_d    = qv_q;
      req_d   = 1'b0;
      wr_d    = wr_q;
      mem_d   = mem_q;
      wdat_d  = wdat_q;
      rdat_d  = rdat_q;
      rd_oe_d = rd_oe_q;
      hold_d  = 1'b0;
      if (qv_q && queue_ready)
         qv_d = 1'b0;
      case (st_q)
         DHBP_IDLE: begin
            if (!sel_n) begin
               hold_d = 1'b1;
               if (tgt == dhbp_pkg::SEL_QUEUE && !wr_n) begin
                  st_d = DHBP_QUEUE;
               end else if (tgt != dhbp_pkg::SEL_QUEUE) begin
                  req_d   = 1'b1;
                  wr_d    = !wr_n;
                  mem_d   = (tgt == dhbp_pkg::SEL_MEM);
                  wdat_d  = lane_s2_q;
                  rd_oe_d = wr_n;
                  st_d    = DHBP_ACCESS;
               end else begin
                  st_d = DHBP_DONE;
               end
            end
         end
         DHBP_QUEUE: begin
            hold_d = 1'b1;
            // Stall the host while the previous word is unsent
            if (!(qv_q && !queue_ready)) begin
               word_d = {word_q[23:0], lane_s2_q};
               bidx_d = bidx_q + 2'h1;
               if (bidx_q == 2'(dhbp_pkg::WORD_BYTES - 1))
                  qv_d = 1'b1;
               hold_d = 1'b0;
               st_d   = DHBP_DONE;
            end
         end
         DHBP_ACCESS: begin
            hold_d = 1'b1;
            if (acc_done) begin
               rdat_d = acc_rdata;
               hold_d = 1'b0;
               st_d   = DHBP_DONE;
            end
         end
         DHBP_DONE: begin
            // Host ends the cycle only after hold is released
            if (sel_n) begin
               rd_oe_d = 1'b0;
               st_d    = DHBP_IDLE;
            end
         end
         default: st_d = DHBP_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q    <= DHBP_IDLE;
         bidx_q  <= dhbp_pkg::BYTE_IDX_RST;
         word_q  <= 32'h0000_0000;
         qv_q    <= 1'b0;
         req_q   <= 1'b0;
         wr_q    <= 1'b0;
         mem_q   <= 1'b0;
         wdat_q  <= 8'h00;
         rdat_q  <= 8'h00;
         rd_oe_q <= 1'b0;
         hold_q  <= 1'b0;
      end else begin
         st_q    <= st_d;
         bidx_q  <= bidx_d;
         word_q  <= word_d;
         qv_q    <= qv_d;
         req_q   <= req_d;
         wr_q    <= wr_d;
         mem_q   <= mem_d;
         wdat_q  <= wdat_d;
         rdat_q  <= rdat_d;
         rd_oe_q <= rd_oe_d;
         hold_q  <= hold_d;
      end
   end

   assign queue_valid       = qv_q;
   assign queue_word        = word_q;
   assign acc_req           = req_q;
   assign acc_wr            = wr_q;
   assign acc_mem           = mem_q;
   assign acc_wdata         = wdat_q;
   assign host_byte_lane_o  = rdat_q;
   assign host_byte_lane_oe = rd_oe_q;

   // Open-drain drivers
   logic irq_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         irq_q <= 1'b0;
      else
         irq_q <= core_irq;
   end

   dhbp_od_pin #(.HIGH_CYC(dhbp_pkg::DRIVE_HIGH_CYC)) u_hold_pin (
      .clk        (clk),
      .nrst       (nrst),
      .assert_req (hold_q),
      .pin_o      (transfer_hold_ack_n_o),
      .pin_oe     (transfer_hold_ack_n_oe)
   );

   dhbp_od_pin #(.HIGH_CYC(dhbp_pkg::DRIVE_HIGH_CYC)) u_int_pin (
      .clk        (clk),
      .nrst       (nrst),
      .assert_req (irq_q),
      .pin_o      (host_int_n_o),
      .pin_oe     (host_int_n_oe)
   );

   // Programmable I/O, direction after reset fixed by constant
   logic [PIO_W-1:0] pdir_q;
   logic [PIO_W-1:0] pdir_d;
   logic [PIO_W-1:0] pout_q;
   logic [PIO_W-1:0] pout_d;
   always_comb begin
      pdir_d = pio_set_we ? pio_dir_set : pdir_q;
      pout_d = pio_set_we ? pio_out_set : pout_q;
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pdir_q <= PIO_W'(dhbp_pkg::PIO_DIR_RST);
         pout_q <= PIO_W'(dhbp_pkg::PIO_OUT_RST);
      end else begin
         pdir_q <= pdir_d;
         pout_q <= pout_d;
      end
   end
   assign prog_io_pin_oe = pdir_q;
   assign prog_io_pin_o  = pout_q;
   assign pio_in_val     = pio_s2_q;

   msb_first_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_q == DHBP_QUEUE && !(qv_q && !queue_ready))
      |=> word_q[7:0] == $past(lane_s2_q))
      else $error("queue byte not shifted in at low end");
   word_count_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_q == DHBP_QUEUE && bidx_q == 2'h3 && !qv_q) |=> qv_q)
      else $error("word not issued after fourth byte");
   hold_on_select_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_q == DHBP_IDLE && !sel_n) |=> ##1 !transfer_hold_ack_n_o)
      else $error("hold not asserted after select");
   access_req_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_q == DHBP_IDLE && !sel_n && tgt != dhbp_pkg::SEL_QUEUE)
      |=> acc_req)
      else $error("register or memory access not requested");
   read_drive_a: assert property (@(posedge clk) disable iff (!nrst)
      host_byte_lane_oe |-> !acc_wr)
      else $error("lane driven during write");
   pio_reset_dir_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(nrst) |-> prog_io_pin_oe[26:19] == 8'hff
         && prog_io_pin_oe[18:11] == 8'h00 && !prog_io_pin_oe[0])
      else $error("pin direction wrong after reset");
   irq_pin_a: assert property (@(posedge clk) disable iff (!nrst)
      irq_q |=> (!host_int_n_o && host_int_n_oe))
      else $error("interrupt not driven low");
   done_wait_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_q == DHBP_DONE && !sel_n) |=> st_q == DHBP_DONE)
      else $error("cycle ended while select held");
endmodule // dhbp_top

/* verif/dhbp_host_model.sv */
// Host processor model for the decoder byte port
`timescale 1ns/1ps
module dhbp_host_model (
   // Clock
   input  wire logic       clk,
   // Wires as the host sees them
   input  wire logic       hold_n,
   input  wire logic [7:0] lane,
   // Host strobes and data
   output logic            port_sel_n,
   output logic            host_wr_n,
   output logic [1:0]      target_sel,
   output logic [7:0]      lane_drv,
   output logic            hung
);
   initial begin
      port_sel_n = 1'b1;
      host_wr_n  = 1'b1;
      target_sel = 2'h0;
      lane_drv   = 8'h00;
      hung       = 1'b0;
   end

   // One byte cycle; data and direction settle before select falls
   task automatic xfer(input logic wr, input logic [1:0] tgt,
                       input logic [7:0] wd, output logic [7:0] rd);
      int n;
      host_wr_n  <= ~wr;
      target_sel <= tgt;
      // Released lane shows the inverse, not a stale value
      lane_drv   <= wr ? wd : ~lane_drv;
      @(posedge clk);
      port_sel_n <= 1'b0;
      n = 0;
      while (hold_n !== 1'b0 && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (n >= 40) hung <= 1'b1;
      while (hold_n !== 1'b1 && n < 80) begin
         @(posedge clk);
         n++;
      end
      if (n >= 80) hung <= 1'b1;
      rd = lane;
      port_sel_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
endmodule // dhbp_host_model

/* verif/dhbp_top_bench.sv */
// Self-checking bench for the decoder host byte port
`timescale 1ns/1ps
module dhbp_top_bench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic sel_n, wr_n, lane_oe, hold_o, hold_oe, int_o, int_oe;
   logic [1:0] tgt;
   logic [7:0] lane_drv, lane_o, lane_i, acc_rdata = 8'h00, acc_wdata;
   logic q_valid, q_ready = 1'b0, acc_req, acc_wr, acc_mem;
   logic acc_done = 1'b0, core_irq = 1'b0, hung, pio_we = 1'b0;
   logic [31:0] q_word, pio_i = '0, pio_o, pio_oe, pio_dir = '0;
   logic [31:0] pio_out = '0, pio_in;
   logic seen_wr, seen_mem, h_oe_q = 1'b0, h_o_q, i_oe_q = 1'b0, i_o_q;
   logic [7:0] seen_wd;
   logic [1:0] dly = 2'h0;
   int err_count = 0;
   int checks_done = 0;
   wire hold_n = hold_oe ? hold_o : 1'b1;
   assign lane_i = lane_oe ? lane_o : lane_drv;

   always #5 clk = ~clk;

   dhbp_top u_dut (.clk(clk), .nrst(nrst), .port_sel_n(sel_n),
      .host_wr_n(wr_n), .target_sel(tgt), .host_byte_lane_i(lane_i),
      .host_byte_lane_o(lane_o), .host_byte_lane_oe(lane_oe),
      .transfer_hold_ack_n_o(hold_o), .transfer_hold_ack_n_oe(hold_oe),
      .host_int_n_o(int_o), .host_int_n_oe(int_oe),
      .queue_valid(q_valid), .queue_word(q_word), .queue_ready(q_ready),
      .acc_req(acc_req), .acc_wr(acc_wr), .acc_mem(acc_mem),
      .acc_wdata(acc_wdata), .acc_done(acc_done), .acc_rdata(acc_rdata),
      .core_irq(core_irq), .prog_io_pin_i(pio_i), .prog_io_pin_o(pio_o),
      .prog_io_pin_oe(pio_oe), .pio_set_we(pio_we), .pio_dir_set(pio_dir),
      .pio_out_set(pio_out), .pio_in_val(pio_in));

   dhbp_host_model u_host (.clk(clk), .hold_n(hold_n), .lane(lane_i),
      .port_sel_n(sel_n), .host_wr_n(wr_n), .target_sel(tgt),
      .lane_drv(lane_drv), .hung(hung));

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Core side answers three cycles late, as a slow memory would
   always @(posedge clk) begin
      dly <= {dly[0], acc_req === 1'b1};
      acc_done <= dly[1];
      // Read data valid only with done, so a late capture shows
      acc_rdata <= dly[1] ? 8'h3c : 8'h00;
      if (acc_req === 1'b1) begin
         seen_wr  <= acc_wr;
         seen_mem <= acc_mem;
         seen_wd  <= acc_wdata;
      end
   end

   // Open-drain pins must leave driven high, never straight from low
   always @(posedge clk) begin
      if (h_oe_q && hold_oe === 1'b0) chk("hold release", h_o_q, 1);
      if (i_oe_q && int_oe === 1'b0) chk("int release", i_o_q, 1);
      h_oe_q <= hold_oe === 1'b1;
      h_o_q  <= hold_o;
      i_oe_q <= int_oe === 1'b1;
      i_o_q  <= int_o;
   end

   task automatic t_reset;
      chk("pio dir", pio_oe, 32'h07f8_0000);
      chk("hold oe", hold_oe, 0);
      chk("int oe", int_oe, 0);
   endtask

   task automatic t_queue;
      logic [7:0] r;
      logic [7:0] wb [4] = '{8'hde, 8'had, 8'hbe, 8'hef};
      for (int i = 0; i < 4; i++) u_host.xfer(1'b1, 2'h0, wb[i], r);
      chk("queue valid", q_valid, 1);
      chk("queue word", q_word, 32'hdead_beef);
      // Fifth byte must stall until the core takes the full word
      fork
         u_host.xfer(1'b1, 2'h0, 8'h11, r);
         begin
            repeat (12) @(posedge clk);
            chk("queue stall", q_word, 32'hdead_beef);
            q_ready <= 1'b1;
            @(posedge clk);
            q_ready <= 1'b0;
         end
      join
      chk("queue taken", q_valid, 0);
      chk("queue shift", q_word, 32'hadbe_ef11);
      chk("host hung", hung, 0);
   endtask

   task automatic t_access;
      logic [7:0] r;
      u_host.xfer(1'b1, 2'h1, 8'ha5, r);
      chk("reg wr", {seen_wr, seen_mem, seen_wd}, 10'h2a5);
      u_host.xfer(1'b0, 2'h2, 8'h00, r);
      chk("mem rd", {seen_wr, seen_mem}, 2'h1);
      chk("rd data", r, 8'h3c);
      chk("lane oe", lane_oe, 0);
      chk("host hung", hung, 0);
   endtask

   task automatic t_irq;
      int n;
      core_irq <= 1'b1;
      n = 0;
      while (!(int_oe === 1'b1 && int_o === 1'b0) && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk("int asserted", n < 20, 1);
      core_irq <= 1'b0;
      repeat (6) @(posedge clk);
      chk("int oe off", int_oe, 0);
   endtask

   task automatic t_pio;
      pio_we  <= 1'b1;
      pio_dir <= 32'hffff_0001;
      pio_out <= 32'h5a5a_0001;
      pio_i   <= 32'h1234_5678;
      @(posedge clk);
      pio_we <= 1'b0;
      @(posedge clk);
      chk("pio oe", pio_oe, 32'hffff_0001);
      chk("pio out", pio_o, 32'h5a5a_0001);
      repeat (4) @(posedge clk);
      chk("pio in", pio_in, 32'h1234_5678);
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      // Full 20 ms reset shortened; the port only needs settled flops
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      t_reset;
      t_queue;
      t_access;
      t_irq;
      t_pio;
      summarize;
   end

   initial begin
      #50000;
      err_count++;
      summarize;
   end
endmodule // dhbp_top_bench
